// file: logic/acmp_pkg.sv
// Package with register map, field positions and reset values of the comparator control block.
`default_nettype none

package acmp_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_FLAG_SET = 8'h0c;
  localparam logic [7:0] OFS_PIN_SEL  = 8'h10;

  // Field positions of analog_compare_control.
  localparam int BIT_COMPARE_ON     = 6;
  localparam int BIT_COMPARE_INVERT = 5;
  localparam int BIT_COMPARE_RESULT = 4;
  localparam int BIT_HYSTERESIS_ON  = 0;

  // Field positions of status, mask, flag-set and pin-select registers.
  localparam int BIT_CHANGE_FLAG = 0;
  localparam int BIT_PIN_INPUT   = 0;
  localparam int BIT_PIN_OUTPUT  = 1;

  // Reset values.
  localparam logic RST_COMPARE_ON     = 1'h0;
  localparam logic RST_COMPARE_INVERT = 1'h0;
  localparam logic RST_COMPARE_RESULT = 1'h0;
  localparam logic RST_HYSTERESIS_ON  = 1'h1;
  localparam logic RST_CHANGE_FLAG    = 1'h0;
  localparam logic RST_MASK           = 1'h0;
  localparam logic RST_PIN_INPUT      = 1'h0;
  localparam logic RST_PIN_OUTPUT     = 1'h0;

  // Bus encodings.
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

`default_nettype wire

// file: logic/compare_level_if.sv
// Interface carrying the filtered comparator level between the synchroniser and the control block.
`timescale 1ns/1ps
`default_nettype none

interface compare_level_if;
  logic level;

  modport src
  (
    output level
  );

  modport sink
  (
    input  level
  );
endinterface

`default_nettype wire

// file: logic/compare_sync.sv
// Three-stage synchroniser and agreement filter for the raw comparator decision.
`timescale 1ns/1ps
`default_nettype none

module compare_sync
  import acmp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // Raw comparator decision from the analog macro.
  input  wire logic        cmp_raw,
  // Filtered level towards the control logic.
  compare_level_if.src     lvl
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = cmp_raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3)
    begin
      nxt_st.level = st_ff.s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign lvl.level = st_ff.level;

  ////////////////////////////////////////////////////////////////////////////
  a_level_agreed: assert property (@(posedge clk) disable iff (!resetn)
    $changed(st_ff.level) |-> ($past(st_ff.s2) == $past(st_ff.s3))
      && (st_ff.level == $past(st_ff.s3)))
    else $error("filtered level changed without two agreeing stages");

endmodule

`default_nettype wire

// file: logic/acmp_ctrl.sv
// Control, status, interrupt and AHB-Lite register logic around the analog comparator.
`timescale 1ns/1ps
`default_nettype none

module acmp_ctrl
  import acmp_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Analog comparator macro.
  input  wire logic        cmp_raw,
  output logic             cmp_power_on,
  output logic             cmp_hyst_on,
  // Shared pins.
  output logic             pullup_cut,
  output logic             cmp_pin_out,
  output logic             cmp_pin_oe,
  // Core power state and event outputs.
  input  wire logic        core_sleep,
  output logic             irq,
  output logic             wake
);

  typedef struct packed {
    logic        compare_on;
    logic        compare_invert;
    logic        compare_result;
    logic        hysteresis_on;
    logic        change_flag;
    logic        change_mask;
    logic        pin_input;
    logic        pin_output;
    logic        pin_level;
    logic        wake_pulse;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
  } ctrl_state_t;

  ctrl_state_t st_ff;
  ctrl_state_t nxt_st;

  compare_level_if lvl_if ();

  logic        take;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_set;
  logic        wr_pin;
  logic        result_changed;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser for the asynchronous comparator decision.
  compare_sync u_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .cmp_raw(cmp_raw),
    .lvl    (lvl_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Only whole-word NONSEQ or SEQ transfers are taken; anything else is
  // answered OKAY, stores nothing and leaves the last read data on hrdata.
  assign take      = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  assign wr_ctrl   = st_ff.ph_write && (st_ff.ph_addr == OFS_CONTROL);
  assign wr_status = st_ff.ph_write && (st_ff.ph_addr == OFS_STATUS);
  assign wr_mask   = st_ff.ph_write && (st_ff.ph_addr == OFS_MASK);
  assign wr_set    = st_ff.ph_write && (st_ff.ph_addr == OFS_FLAG_SET);
  assign wr_pin    = st_ff.ph_write && (st_ff.ph_addr == OFS_PIN_SEL);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_st         = st_ff;
    result_changed = 1'h0;
    rd_word        = 32'h0;

    if (wr_ctrl)
    begin
      nxt_st.compare_on     = hwdata[BIT_COMPARE_ON];
      nxt_st.compare_invert = hwdata[BIT_COMPARE_INVERT];
      nxt_st.hysteresis_on  = hwdata[BIT_HYSTERESIS_ON];
    end
    if (wr_mask)
    begin
      nxt_st.change_mask = hwdata[BIT_CHANGE_FLAG];
    end
    if (wr_pin)
    begin
      nxt_st.pin_input  = hwdata[BIT_PIN_INPUT];
      nxt_st.pin_output = hwdata[BIT_PIN_OUTPUT];
    end

    // The result is recomputed every cycle from the synchronised level,
    // regardless of the core's sleep state; only the enable stops it.
    nxt_st.compare_result = nxt_st.compare_on
      && (lvl_if.level ^ nxt_st.compare_invert);
    result_changed = nxt_st.compare_result != st_ff.compare_result;

    // A change in the same cycle as a write-one-to-clear keeps the flag set.
    nxt_st.change_flag = (st_ff.change_flag && !(wr_status && hwdata[BIT_CHANGE_FLAG]))
      || result_changed
      || (wr_set && hwdata[BIT_CHANGE_FLAG]);

    // A flag that software already set high suppresses the wake event.
    nxt_st.wake_pulse = result_changed && core_sleep && st_ff.compare_on
      && !st_ff.change_flag;

    nxt_st.pin_level = nxt_st.compare_result;

    // Read data comes from next-state values so a read right after a write
    // returns the freshly written contents.
    if (haddr[7:0] == OFS_CONTROL)
    begin
      rd_word[BIT_COMPARE_ON]     = nxt_st.compare_on;
      rd_word[BIT_COMPARE_INVERT] = nxt_st.compare_invert;
      rd_word[BIT_COMPARE_RESULT] = nxt_st.compare_result;
      rd_word[BIT_HYSTERESIS_ON]  = nxt_st.hysteresis_on;
    end
    else if (haddr[7:0] == OFS_STATUS)
    begin
      rd_word[BIT_CHANGE_FLAG] = nxt_st.change_flag;
    end
    else if (haddr[7:0] == OFS_MASK)
    begin
      rd_word[BIT_CHANGE_FLAG] = nxt_st.change_mask;
    end
    else if (haddr[7:0] == OFS_PIN_SEL)
    begin
      rd_word[BIT_PIN_INPUT]  = nxt_st.pin_input;
      rd_word[BIT_PIN_OUTPUT] = nxt_st.pin_output;
    end
    else
    begin
      rd_word = 32'h0;
    end

    nxt_st.ph_write = take && hwrite;
    nxt_st.ph_addr  = take ? haddr[7:0] : 8'h0;
    if (take && !hwrite && (haddr[31:8] == 24'h0))
    begin
      nxt_st.rdata = rd_word;
    end
    else if (take)
    begin
      nxt_st.rdata = 32'h0;
    end
    if (take && (haddr[31:8] != 24'h0))
    begin
      nxt_st.ph_write = 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_ff                <= '0;
      st_ff.compare_on     <= RST_COMPARE_ON;
      st_ff.compare_invert <= RST_COMPARE_INVERT;
      st_ff.compare_result <= RST_COMPARE_RESULT;
      st_ff.hysteresis_on  <= RST_HYSTERESIS_ON;
      st_ff.change_flag    <= RST_CHANGE_FLAG;
      st_ff.change_mask    <= RST_MASK;
      st_ff.pin_input      <= RST_PIN_INPUT;
      st_ff.pin_output     <= RST_PIN_OUTPUT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign hreadyout    = 1'h1;
  assign hresp        = 1'h0;
  assign hrdata       = st_ff.rdata;
  assign cmp_power_on = st_ff.compare_on;
  assign cmp_hyst_on  = st_ff.hysteresis_on;
  assign pullup_cut   = st_ff.pin_input;
  assign cmp_pin_out  = st_ff.pin_output && st_ff.pin_level;
  assign cmp_pin_oe   = st_ff.pin_output;
  assign irq          = st_ff.change_flag && st_ff.change_mask;
  assign wake         = st_ff.wake_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_off_result_low: assert property (@(posedge clk) disable iff (!resetn)
    !st_ff.compare_on |-> !st_ff.compare_result && !cmp_power_on)
    else $error("result not low while comparator disabled");

  a_result_polarity: assert property (@(posedge clk) disable iff (!resetn)
    st_ff.compare_on && $past(st_ff.compare_on)
      |-> st_ff.compare_result == ($past(lvl_if.level) ^ st_ff.compare_invert))
    else $error("result does not follow level and polarity");

  a_result_readback: assert property (@(posedge clk) disable iff (!resetn)
    take && !hwrite && (haddr == 32'h0) && !wr_ctrl
      |=> hrdata[BIT_COMPARE_RESULT] == st_ff.compare_result)
    else $error("result bit readback mismatch");

  a_hyst_reset_one: assert property (@(posedge clk) disable iff (!resetn)
    $past(!resetn) |-> st_ff.hysteresis_on && cmp_hyst_on)
    else $error("hysteresis not on after reset");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    take && !hwrite && (haddr == 32'h0)
      |=> (hrdata[7] == 1'h0) && (hrdata[3:1] == 3'h0) && (hrdata[31:8] == 24'h0))
    else $error("reserved control bits not zero");

  a_change_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    $changed(st_ff.compare_result) |-> st_ff.change_flag)
    else $error("result change did not set flag");

  a_irq_on_flag: assert property (@(posedge clk) disable iff (!resetn)
    result_changed && nxt_st.change_mask |=> irq)
    else $error("enabled flag did not raise interrupt");

  a_wake_cause: assert property (@(posedge clk) disable iff (!resetn)
    wake |-> $past(core_sleep) && $changed(st_ff.compare_result)
      && st_ff.change_flag ##1 !wake)
    else $error("wake without sleeping result change");

  a_no_wake_preset: assert property (@(posedge clk) disable iff (!resetn)
    $past(st_ff.change_flag) |-> !wake)
    else $error("wake raised with flag already high");

  a_pin_follows: assert property (@(posedge clk) disable iff (!resetn)
    cmp_pin_oe |-> cmp_pin_out == st_ff.compare_result)
    else $error("output pin does not carry result");

  a_pin_idle_low: assert property (@(posedge clk) disable iff (!resetn)
    !cmp_pin_oe |-> !cmp_pin_out)
    else $error("output pin high while not driven");

  a_pullup_follows: assert property (@(posedge clk) disable iff (!resetn)
    wr_pin |=> pullup_cut == $past(hwdata[BIT_PIN_INPUT]))
    else $error("pull-high cut does not follow pin select write");

  ////////////////////////////////////////////////////////////////////////////
  // Flag corner cases. A set source and a clear can meet in one cycle; the set
  // must win, otherwise software would lose a result change it never saw.
  a_flag_set_wins: assert property (@(posedge clk) disable iff (!resetn)
    wr_status && hwdata[BIT_CHANGE_FLAG] && result_changed |=> st_ff.change_flag)
    else $error("result change lost against flag clear");

  a_status_clear: assert property (@(posedge clk) disable iff (!resetn)
    wr_status && hwdata[BIT_CHANGE_FLAG] && !result_changed |=> !st_ff.change_flag)
    else $error("write one did not clear flag");

  a_flag_preset: assert property (@(posedge clk) disable iff (!resetn)
    wr_set && hwdata[BIT_CHANGE_FLAG] |=> st_ff.change_flag)
    else $error("flag-set write did not set flag");

  ////////////////////////////////////////////////////////////////////////////
  // Low-power behaviour. The comparator has no sleep input of its own, so only a
  // control write may change its power state while the core sleeps.
  a_wake_in_sleep: assert property (@(posedge clk) disable iff (!resetn)
    $changed(st_ff.compare_result) && $past(core_sleep) && $past(st_ff.compare_on)
      && !$past(st_ff.change_flag) |-> wake)
    else $error("result change while asleep did not wake core");

  a_power_hold: assert property (@(posedge clk) disable iff (!resetn)
    core_sleep && !wr_ctrl |=> $stable(cmp_power_on))
    else $error("comparator power changed without control write");

  ////////////////////////////////////////////////////////////////////////////
  // Bus refusals and read data hold.
  a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
    take && !hwrite && (haddr[31:8] != 24'h0) |=> hrdata == 32'h0)
    else $error("unmapped read returned data");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !take |=> $stable(hrdata))
    else $error("read data changed without a transfer");

endmodule

`default_nettype wire

// file: dv/analog_inputs.sv
// Behavioural model of the two analog voltages at the comparator inputs.
`timescale 1ns/1ps
`default_nettype none

module analog_inputs
(
  // Comparator control from the block.
  input  wire logic       power_on,
  input  wire logic       hyst_on,
  // Input voltages in arbitrary steps.
  input  wire logic [7:0] v_plus,
  input  wire logic [7:0] v_minus,
  // Raw decision towards the block.
  output var logic        cmp_raw
);
  initial cmp_raw = 1'b0;

  // With hysteresis a difference of two steps or less keeps the old decision.
  always @(power_on or hyst_on or v_plus or v_minus)
  begin
    if (!power_on)
      cmp_raw = 1'b0;
    else if (!hyst_on || v_plus > v_minus + 8'd2 || v_plus + 8'd2 < v_minus)
      cmp_raw = v_plus > v_minus;
  end
endmodule

`default_nettype wire

// file: dv/testbench.sv
// Self-checking testbench of the comparator control block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import acmp_pkg::*;
  logic clk, resetn, hsel, hwrite, core_sleep, cmp_raw, irq, wake;
  logic hready, hresp, power_on, hyst_on, pullup_cut, pin_out, pin_oe;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  v_plus, v_minus;
  int          error_cnt, comparisons, cyc, wake_cnt;
  logic [31:0] q;
  logic        inv;

  acmp_ctrl i_acmp_ctrl (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .cmp_raw(cmp_raw),
    .cmp_power_on(power_on), .cmp_hyst_on(hyst_on), .pullup_cut(pullup_cut),
    .cmp_pin_out(pin_out), .cmp_pin_oe(pin_oe), .core_sleep(core_sleep), .irq(irq),
    .wake(wake));
  analog_inputs i_analog_inputs (.power_on(power_on), .hyst_on(hyst_on), .v_plus(v_plus),
    .v_minus(v_minus), .cmp_raw(cmp_raw));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (wake === 1'b1)
      wake_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The master holds each phase until hready is seen high at a rising edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic pin(input logic got, input logic exp);
    @(negedge clk);
    chk({31'h0, got}, {31'h0, exp});
    @(posedge clk);
  endtask

  // Five edges pass from an input change to the stored result.
  task automatic setv(input logic [7:0] p, input logic [7:0] m);
    v_plus  <= p;
    v_minus <= m;
    repeat (7) @(posedge clk);
  endtask

  function automatic logic [31:0] ctl(logic on, logic iv, logic p_gt_m);
    return {25'h0, on, iv, on & (p_gt_m ^ iv), 4'h1};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {resetn, hsel, hwrite, core_sleep, haddr, hwdata, htrans} = '0;
    hsize   = HSIZE_WORD;
    v_plus  = 8'h0a;
    v_minus = 8'hc8;
    void'($urandom(96));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_CONTROL, 32'h01);
    rd(32'h100, 32'h0);
    wr(OFS_CONTROL, 32'hffffffcf);
    rd(OFS_CONTROL, 32'h41);
    pin(power_on, 1'b1);
    pin(hyst_on, 1'b1);
    wr(OFS_STATUS, 32'h1);
    setv(8'hc8, 8'h0a);
    rd(OFS_CONTROL, 32'h51);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_CONTROL, 32'h61);
    rd(OFS_CONTROL, 32'h61);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_MASK, 32'h1);
    pin(irq, 1'b1);
    wr(OFS_STATUS, 32'h1);
    pin(irq, 1'b0);
    // Wake-up while asleep, then blocked by presetting the flag.
    core_sleep <= 1'b1;
    wr(OFS_CONTROL, 32'h41);
    wr(OFS_STATUS, 32'h1);
    wake_cnt = 0;
    setv(8'h0a, 8'hc8);
    chk(wake_cnt, 1);
    pin(irq, 1'b1);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_FLAG_SET, 32'h1);
    rd(OFS_STATUS, 32'h1);
    wake_cnt = 0;
    setv(8'hc8, 8'h0a);
    chk(wake_cnt, 0);
    rd(OFS_CONTROL, 32'h51);
    core_sleep <= 1'b0;
    wr(OFS_STATUS, 32'h1);
    wr(OFS_CONTROL, 32'h01);
    rd(OFS_CONTROL, 32'h01);
    rd(OFS_STATUS, 32'h1);
    pin(power_on, 1'b0);
    // A halfword write must be ignored.
    hsize <= 3'h1;
    wr(OFS_CONTROL, 32'h41);
    hsize <= HSIZE_WORD;
    rd(OFS_CONTROL, 32'h01);
    wr(OFS_PIN_SEL, 32'h3);
    pin(pullup_cut, 1'b1);
    pin(pin_oe, 1'b1);
    // Random levels and polarities; differences stay outside the hysteresis band.
    repeat (10)
    begin
      inv = $urandom % 2;
      core_sleep <= $urandom % 2;
      wr(OFS_CONTROL, ctl(1'b1, inv, 1'b0));
      if ($urandom % 2)
        setv(8'h8c + 8'($urandom % 100), 8'h80);
      else
        setv(8'h0a + 8'($urandom % 100), 8'h80);
      rd(OFS_CONTROL, ctl(1'b1, inv, v_plus > v_minus));
      pin(pin_out, inv ^ (v_plus > v_minus));
    end
    // Reset in mid-run brings the control and pin-select registers back to their reset values.
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_CONTROL, 32'h01);
    rd(OFS_PIN_SEL, 32'h0);
    pin(pin_oe, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
